// *** common/ieal_pkg.sv ***
// Shared constants and types for the serial EEPROM access logic.
package ieal_pkg;

  localparam int          ADDR_W      = 16;
  localparam int          PAGE_W      = 7;
  localparam int          MEM_BYTES   = 65536;
  localparam int          PAGE_BYTES  = 128;
  localparam int          PAGE_COUNT  = 512;
  localparam logic [7:0]  ERASED_BYTE = 8'hFF;
  localparam logic [3:0]  DEV_TYPE    = 4'hA;
  localparam logic [3:0]  BIT_LAST    = 4'h8;
  localparam logic [3:0]  BIT_ZERO    = 4'h0;
  localparam logic [6:0]  IDX_ONE     = 7'h01;
  localparam logic [15:0] ADDR_ONE    = 16'h0001;
  localparam logic [1:0]  FIFO_DEPTH  = 2'h2;
  localparam logic [1:0]  FIFO_ONE    = 2'h1;
  localparam logic [1:0]  FIFO_ZERO   = 2'h0;

  // Programming time and the clock that counts it.
  localparam int CLK_HZ     = 25000000;
  localparam int T_WR_US    = 5000;
  localparam int WR_CYCLES  = (CLK_HZ / 1000000) * T_WR_US;

  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_DEV   = 6'h02,
    ST_ADRH  = 6'h04,
    ST_ADRL  = 6'h08,
    ST_WDATA = 6'h10,
    ST_RDATA = 6'h20
  } ieal_state_e;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  data;
  } ieal_rd_ent_s;

endpackage : ieal_pkg

// *** rtl/ieal_top.sv ***
// Slave access logic of a 64 KiB two-wire serial EEPROM.
`timescale 1ns/1ps
`default_nettype none

module ieal_top #(
  parameter int WR_CYCLES = ieal_pkg::WR_CYCLES
) (
  input  wire logic       CLK_I,
  input  wire logic       SRST_I,
  input  wire logic       SCL_I,
  input  wire logic       SDA_I,
  output var  logic       SDA_O,
  output var  logic       SDA_OE_O,
  input  wire logic       WP_I,
  input  wire logic [2:0] CHIP_SELECT_STRAPS_I,
  output var  logic       BUSY_O
);

  // Two-flop synchronisers for the bus, WP and strap pins, plus a third stage on SCL and SDA for edges.
  logic [2:0] scl_q, sda_q;
  logic [1:0] wp_q;
  logic [2:0] strap_m_q, strap_q;

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      scl_q     <= 3'h7;
      sda_q     <= 3'h7;
      wp_q      <= 2'h0;
      strap_m_q <= 3'h0;
      strap_q   <= 3'h0;
    end else begin
      scl_q     <= {scl_q[1:0], SCL_I};
      sda_q     <= {sda_q[1:0], SDA_I};
      wp_q      <= {wp_q[0], WP_I};
      strap_m_q <= CHIP_SELECT_STRAPS_I;
      strap_q   <= strap_m_q;
    end
  end

  wire scl_s    = scl_q[1];
  wire scl_p    = scl_q[2];
  wire sda_s    = sda_q[1];
  wire sda_p    = sda_q[2];
  wire wp_s     = wp_q[1];
  wire scl_rise = scl_s & ~scl_p;
  wire scl_fall = ~scl_s & scl_p;
  wire bus_start = scl_s & scl_p & sda_p & ~sda_s;
  wire bus_stop  = scl_s & scl_p & ~sda_p & sda_s;

  // Protocol state.
  ieal_pkg::ieal_state_e state_q;
  logic [3:0]  cnt_q;
  logic        in9_q;
  logic [7:0]  rx_q;
  logic [7:0]  tx_q;
  logic        oe_q;
  logic [7:0]  adrh_q;
  logic [15:0] ptr_q;
  logic        rej_q;
  logic        seen_q;
  logic        rw_q;
  logic        sda_rx_nack_q;

  // Programming state.
  logic        busy_q;
  logic [31:0] wr_cnt_q;
  logic [7:0]  cidx_q;
  logic        commit;

  // Page buffer and storage array.
  logic [7:0]  pbuf [ieal_pkg::PAGE_BYTES];
  logic [ieal_pkg::PAGE_BYTES-1:0] mask_q;
  logic [7:0]  mem [ieal_pkg::MEM_BYTES] = '{default: ieal_pkg::ERASED_BYTE};

  // Read prefetch buffer, two entries.
  ieal_pkg::ieal_rd_ent_s fifo [2];
  logic        wr_ix_q, rd_ix_q;
  logic [1:0]  fcnt_q;
  logic [15:0] pf_addr_q;

  wire st_idle  = (state_q == ieal_pkg::ST_IDLE);
  wire st_dev   = (state_q == ieal_pkg::ST_DEV);
  wire st_adrh  = (state_q == ieal_pkg::ST_ADRH);
  wire st_adrl  = (state_q == ieal_pkg::ST_ADRL);
  wire st_wdata = (state_q == ieal_pkg::ST_WDATA);
  wire st_rdata = (state_q == ieal_pkg::ST_RDATA);

  wire ack_slot = scl_fall & (cnt_q == ieal_pkg::BIT_LAST) & ~in9_q;
  wire end_slot = scl_fall & in9_q;
  wire bit_slot = scl_fall & ~in9_q & (cnt_q != ieal_pkg::BIT_LAST) & st_rdata;
  wire dev_match = (rx_q[7:4] == ieal_pkg::DEV_TYPE) & (rx_q[3:1] == strap_q);
  wire dev_ack   = dev_match & ~busy_q;
  wire data_ok   = st_wdata & ~rej_q;
  wire go_read   = end_slot & st_dev & rw_q;
  wire go_next   = end_slot & st_rdata & ~sda_rx_nack_q;

  // Prefetch handshake: filling side is the array reader, draining side
  // is the byte shifter; the reader stalls whenever both entries are full.
  wire f_full   = (fcnt_q == ieal_pkg::FIFO_DEPTH);
  wire f_valid  = (fcnt_q != ieal_pkg::FIFO_ZERO);
  wire f_flush  = st_idle | st_adrh | st_adrl | st_wdata | busy_q;
  wire f_ready  = ~f_full & ~f_flush;
  wire f_pop    = (go_read | go_next) & f_valid;
  wire f_push   = f_ready;
  ieal_pkg::ieal_rd_ent_s f_head, f_in;
  assign f_head = fifo[rd_ix_q];
  assign f_in   = '{addr: pf_addr_q, data: mem[pf_addr_q]};
  wire [7:0] next_byte = f_valid ? f_head.data : ieal_pkg::ERASED_BYTE;

  assign commit = bus_stop & st_wdata & seen_q & ~rej_q;
  wire [ieal_pkg::PAGE_W-1:0] cidx = cidx_q[ieal_pkg::PAGE_W-1:0];
  wire commit_step = busy_q & ~cidx_q[ieal_pkg::PAGE_W];

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      state_q       <= ieal_pkg::ST_IDLE;
      cnt_q         <= ieal_pkg::BIT_ZERO;
      in9_q         <= 1'b0;
      rx_q          <= 8'h00;
      tx_q          <= 8'h00;
      oe_q          <= 1'b0;
      adrh_q        <= 8'h00;
      ptr_q         <= 16'h0000;
      rej_q         <= 1'b0;
      seen_q        <= 1'b0;
      rw_q          <= 1'b0;
      sda_rx_nack_q <= 1'b0;
    end else if (bus_start) begin
      state_q <= ieal_pkg::ST_DEV;
      cnt_q   <= ieal_pkg::BIT_ZERO;
      in9_q   <= 1'b0;
      oe_q    <= 1'b0;
    end else if (bus_stop) begin
      state_q <= ieal_pkg::ST_IDLE;
      in9_q   <= 1'b0;
      oe_q    <= 1'b0;
    end else if (!st_idle) begin
      if (scl_rise && cnt_q != ieal_pkg::BIT_LAST) begin
        rx_q  <= {rx_q[6:0], sda_s};
        cnt_q <= cnt_q + 4'h1;
      end else if (scl_rise) begin
        sda_rx_nack_q <= sda_s;
      end
      if (ack_slot) begin
        in9_q <= 1'b1;
        case (state_q)
          ieal_pkg::ST_DEV: begin
            oe_q <= dev_ack;
            rw_q <= rx_q[0];
            if (!dev_ack) begin
              state_q <= ieal_pkg::ST_IDLE;
            end
          end
          ieal_pkg::ST_ADRH: begin
            oe_q   <= 1'b1;
            adrh_q <= rx_q;
          end
          ieal_pkg::ST_ADRL: begin
            oe_q   <= 1'b1;
            ptr_q  <= {adrh_q, rx_q};
            seen_q <= 1'b0;
          end
          ieal_pkg::ST_WDATA: begin
            oe_q <= data_ok;
            if (data_ok) begin
              seen_q     <= 1'b1;
              ptr_q[6:0] <= ptr_q[6:0] + ieal_pkg::IDX_ONE;
            end
          end
          default: begin
            oe_q <= 1'b0;
          end
        endcase
      end else if (end_slot) begin
        in9_q <= 1'b0;
        cnt_q <= ieal_pkg::BIT_ZERO;
        oe_q  <= 1'b0;
        case (state_q)
          ieal_pkg::ST_DEV: begin
            state_q <= rw_q ? ieal_pkg::ST_RDATA : ieal_pkg::ST_ADRH;
            if (rw_q) begin
              tx_q <= next_byte;
              oe_q <= ~next_byte[7];
            end
          end
          ieal_pkg::ST_ADRH: begin
            state_q <= ieal_pkg::ST_ADRL;
          end
          ieal_pkg::ST_ADRL: begin
            state_q <= ieal_pkg::ST_WDATA;
            rej_q   <= wp_s;
          end
          ieal_pkg::ST_RDATA: begin
            if (sda_rx_nack_q) begin
              state_q <= ieal_pkg::ST_IDLE;
            end else begin
              tx_q <= next_byte;
              oe_q <= ~next_byte[7];
            end
          end
          default: begin
            state_q <= state_q;
          end
        endcase
        if (f_pop) begin
          ptr_q <= f_head.addr + ieal_pkg::ADDR_ONE;
        end
      end else if (bit_slot) begin
        tx_q <= {tx_q[6:0], 1'b1};
        oe_q <= ~tx_q[6];
      end
    end
  end

  assign SDA_O    = 1'b0;
  assign SDA_OE_O = oe_q;
  assign BUSY_O   = busy_q;

  // Page buffer loads with the page index that wraps inside the page.
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      mask_q <= '0;
    end else if (ack_slot && st_adrl) begin
      mask_q <= '0;
    end else if (ack_slot && data_ok) begin
      mask_q[ptr_q[6:0]] <= 1'b1;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (ack_slot && data_ok) begin
      pbuf[ptr_q[6:0]] <= rx_q;
    end
  end

  // Programming cycle: step through the page one byte index per cycle, writing only the loaded bytes, while the time counts down.
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      busy_q   <= 1'b0;
      wr_cnt_q <= 32'h0000_0000;
      cidx_q   <= 8'h00;
    end else if (commit) begin
      busy_q   <= 1'b1;
      wr_cnt_q <= 32'(WR_CYCLES);
      cidx_q   <= 8'h00;
    end else if (busy_q) begin
      wr_cnt_q <= wr_cnt_q - 32'h0000_0001;
      busy_q   <= (wr_cnt_q != 32'h0000_0001);
      if (commit_step) begin
        cidx_q <= cidx_q + 8'h01;
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (commit_step && mask_q[cidx]) begin
      mem[{ptr_q[15:7], cidx}] <= pbuf[cidx];
    end
  end

  // Prefetch buffer.
  always_ff @(posedge CLK_I) begin
    if (SRST_I || f_flush) begin
      wr_ix_q   <= 1'b0;
      rd_ix_q   <= 1'b0;
      fcnt_q    <= ieal_pkg::FIFO_ZERO;
      pf_addr_q <= ptr_q;
    end else begin
      if (f_push) begin
        wr_ix_q   <= ~wr_ix_q;
        pf_addr_q <= pf_addr_q + ieal_pkg::ADDR_ONE;
      end
      if (f_pop) begin
        rd_ix_q <= ~rd_ix_q;
      end
      if (f_push && !f_pop) begin
        fcnt_q <= fcnt_q + ieal_pkg::FIFO_ONE;
      end else if (f_pop && !f_push) begin
        fcnt_q <= fcnt_q - ieal_pkg::FIFO_ONE;
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (f_push) begin
      fifo[wr_ix_q] <= f_in;
    end
  end

  // Checks.
  sequence s_wr_end;
    bus_stop && st_wdata && seen_q && !rej_q;
  endsequence

  sequence s_dev_slot;
    ack_slot && st_dev;
  endsequence

  busy_nack_a: assert property (@(posedge CLK_I) disable iff (SRST_I)
    s_dev_slot and busy_q |=> !SDA_OE_O)
    else $error("Address acknowledged while programming.");

  dev_ack_a: assert property (@(posedge CLK_I) disable iff (SRST_I)
    s_dev_slot ##0 dev_match && !busy_q |=> SDA_OE_O)
    else $error("Matching address not acknowledged.");

  wp_reject_a: assert property (@(posedge CLK_I) disable iff (SRST_I)
    ack_slot && st_wdata && rej_q |=> !SDA_OE_O && !seen_q ##0 $stable(mask_q))
    else $error("Protected data byte was taken.");

  stop_commit_a: assert property (@(posedge CLK_I) disable iff (SRST_I)
    s_wr_end |=> busy_q [*2])
    else $error("Programming did not start on write stop.");

  read_stop_a: assert property (@(posedge CLK_I) disable iff (SRST_I)
    bus_stop && !st_wdata && !busy_q |=> !busy_q && st_idle)
    else $error("Stop after read started programming.");

  empty_write_a: assert property (@(posedge CLK_I) disable iff (SRST_I)
    bus_stop && st_wdata && (rej_q || !seen_q) && !busy_q |=> !busy_q)
    else $error("Empty or rejected write started programming.");

  ptr_inc_a: assert property (@(posedge CLK_I) disable iff (SRST_I)
    ack_slot && data_ok |=> ptr_q[6:0] == $past(ptr_q[6:0]) + 7'h01
      && ptr_q[15:7] == $past(ptr_q[15:7]))
    else $error("Write counter did not step inside its page.");

  pop_ptr_a: assert property (@(posedge CLK_I) disable iff (SRST_I)
    f_pop |=> ptr_q == $past(f_head.addr) + 16'h0001)
    else $error("Counter does not follow the sent byte.");

  fifo_safe_a: assert property (@(posedge CLK_I) disable iff (SRST_I)
    f_full |-> !f_push ##0 fcnt_q <= ieal_pkg::FIFO_DEPTH)
    else $error("Prefetch buffer overrun.");

endmodule : ieal_top

`default_nettype wire

// *** test/ieal_master.sv ***
// Two-wire bus master model that drives the bus clock and its share of the data line.
`timescale 1ns/1ps
`default_nettype none

module ieal_master (
  input  wire logic clk_i,
  input  wire logic sda_i,
  output var  logic scl_o,
  output var  logic sda_o
);
  // The bus idles high through its pull-ups, so both lines start released.
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : wt
  // Start or repeated start: data falls while the clock is high.
  task automatic start;
    wt(2);
    sda_o = 1'b1;
    wt(2);
    scl_o = 1'b1;
    wt(4);
    sda_o = 1'b0;
    wt(4);
    scl_o = 1'b0;
  endtask : start
  // Stop: data rises while the clock is high, then the clock stands high.
  task automatic stop;
    wt(2);
    sda_o = 1'b0;
    wt(2);
    scl_o = 1'b1;
    wt(4);
    sda_o = 1'b1;
    wt(4);
  endtask : stop
  // One clock pulse; data is set mid-low and sampled late in the high phase.
  task automatic bit_x(input logic b, output logic s);
    wt(2);
    sda_o = b;
    wt(2);
    scl_o = 1'b1;
    wt(3);
    s = sda_i;
    wt(1);
    scl_o = 1'b0;
  endtask : bit_x
  task automatic tx(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], s);
    end
    bit_x(1'b1, s);
    ack = ~s;
  endtask : tx
  task automatic rx(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, s);
      d[i] = s;
    end
    bit_x(~ack, s);
  endtask : rx
endmodule : ieal_master
`default_nettype wire

// *** test/testbench.sv ***
// Self-checking bench for the serial EEPROM access logic.
`timescale 1ns/1ps
`default_nettype none

module testbench;
  localparam int WRC = 200;
  logic       clk = 1'b0;
  logic       srst = 1'b1;
  logic       wp = 1'b0;
  logic [2:0] straps = 3'h5;
  wire        scl, m_sda, sda_oe, sda_o, busy;
  wire        sda = m_sda & (sda_oe ? sda_o : 1'b1);
  int         fail_count = 0;
  int         comparisons = 0;
  int         cyc = 0;
  logic [7:0] expm [int];
  always #20 clk = ~clk;
  ieal_master u_mst (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_o(m_sda));
  ieal_top #(.WR_CYCLES(WRC)) u_dut (.CLK_I(clk), .SRST_I(srst), .SCL_I(scl), .SDA_I(sda),
    .SDA_O(sda_o), .SDA_OE_O(sda_oe), .WP_I(wp), .CHIP_SELECT_STRAPS_I(straps), .BUSY_O(busy));
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp8
  task automatic cmp1(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp1
  // Expected array content; unwritten bytes read as erased.
  function automatic logic [7:0] ex(input logic [15:0] a);
    return expm.exists(a) ? expm[a] : ieal_pkg::ERASED_BYTE;
  endfunction : ex
  task automatic dev(input logic rd, input logic exp);
    logic k;
    u_mst.start();
    u_mst.tx({ieal_pkg::DEV_TYPE, straps, rd}, k);
    cmp1(k, exp);
  endtask : dev
  task automatic sel(input logic [15:0] a);
    logic k;
    dev(1'b0, 1'b1);
    u_mst.tx(a[15:8], k);
    cmp1(k, 1'b1);
    u_mst.tx(a[7:0], k);
    cmp1(k, 1'b1);
  endtask : sel
  task automatic wait_busy(input logic b, input int lim);
    for (int t = 0; t < lim && busy !== b; t++) begin
      @(posedge clk);
      #1;
    end
    cmp1(busy, b);
  endtask : wait_busy
  task automatic idle_chk;
    repeat (20) @(posedge clk);
    #1;
    cmp1(busy, 1'b0);
  endtask : idle_chk
  task automatic rd(input logic imm, input logic [15:0] a, input int n);
    logic [7:0] d;
    if (!imm) begin
      sel(a);
    end
    dev(1'b1, 1'b1);
    for (int i = 0; i < n; i++) begin
      u_mst.rx(i < n - 1, d);
      cmp8(d, ex(16'(a + i)));
    end
    u_mst.stop();
    idle_chk();
  endtask : rd
  task automatic wr(input logic [15:0] a, input int n, input logic [7:0] d0);
    logic k;
    sel(a);
    for (int i = 0; i < n; i++) begin
      u_mst.tx(d0 + 8'(i), k);
      cmp1(k, 1'b1);
      expm[{a[15:7], 7'(a[6:0] + i)}] = d0 + 8'(i);
    end
    u_mst.stop();
    wait_busy(1'b1, 12);
    dev(1'b0, 1'b0);
    u_mst.stop();
    wait_busy(1'b0, WRC);
    dev(1'b0, 1'b1);
    u_mst.stop();
  endtask : wr
  task automatic t_byte;
    wr(16'h0001, 1, 8'h5A);
    rd(1'b0, 16'h0001, 1);
    $display("done: byte write");
  endtask : t_byte
  task automatic t_page;
    wr(16'h00FE, 130, 8'h10);
    rd(1'b0, 16'h0080, 128);
    $display("done: page write");
  endtask : t_page
  task automatic t_protect;
    logic k;
    wp = 1'b1;
    sel(16'h0200);
    u_mst.tx(8'h33, k);
    cmp1(k, 1'b0);
    u_mst.stop();
    wp = 1'b0;
    idle_chk();
    rd(1'b0, 16'h0200, 1);
    $display("done: write protect");
  endtask : t_protect
  task automatic t_addr;
    logic k;
    for (int i = 0; i < 2; i++) begin
      u_mst.start();
      u_mst.tx(i == 0 ? 8'hBA : {4'hA, 3'h2, 1'b1}, k);
      cmp1(k, 1'b0);
      u_mst.stop();
    end
    sel(16'h0300);
    u_mst.stop();
    idle_chk();
    rd(1'b0, 16'h0300, 1);
    $display("done: address and empty write");
  endtask : t_addr
  task automatic t_wrap;
    rd(1'b0, 16'hFFFF, 2);
    rd(1'b1, 16'h0001, 1);
    $display("done: read wrap");
  endtask : t_wrap
  initial begin
    repeat (8) @(posedge clk);
    #1;
    srst = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    t_byte();
    t_page();
    t_protect();
    t_addr();
    t_wrap();
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
